// ===== wblu_consts.svh
// Constants for the work bit logic unit
`ifndef WBLU_CONSTS_SVH
`define WBLU_CONSTS_SVH
`define WBLU_NUM_WB 8
`define WBLU_NUM_IEV 6
`define WBLU_CLK_HZ 125000000
`define WBLU_TICK_S 1
`define WBLU_TICK_CYC (`WBLU_CLK_HZ * `WBLU_TICK_S)
`define WBLU_MIN_PRE 6'h3B
`define WBLU_DLY_MAX 14'h270F
`define WBLU_SRC_OFF 6'h00
`define WBLU_SRC_ON 6'h01
`define WBLU_SRC_PON 6'h02
`define WBLU_SRC_EV1 6'h03
`define WBLU_SRC_EV6 6'h08
`define WBLU_SRC_AL1 6'h09
`define WBLU_SRC_AL4 6'h0C
`define WBLU_SRC_RUN 6'h14
`define WBLU_SRC_WB1 6'h1D
`define WBLU_SRC_WB8 6'h24
`define WBLU_IEV_EV1 4'h1
`define WBLU_IEV_EV6 4'h6
`define WBLU_IEV_WB1 4'h7
`define WBLU_IEV_WB8 4'hE
`define WBLU_FN_NONE 3'h0
`define WBLU_FN_RUNSTOP 3'h1
`define WBLU_FN_COMMWR 3'h2
`define WBLU_OUT_NONE 4'h0
`define WBLU_OUT_WB1 4'h1
`define WBLU_OUT_WB8 4'h8
// Register byte offsets
`define WBLU_A_CTRL 12'h000
`define WBLU_A_STAT 12'h004
`define WBLU_A_IEV 12'h008
`define WBLU_A_OUTS 12'h00C
`define WBLU_A_WBCFG 12'h100
`define WBLU_A_WBDLY 12'h140
`endif

// ===== wblu_pkg.sv
// Types for the work bit logic unit
package wblu_pkg;
    typedef enum logic [2:0] {
        WBLU_OP_NONE = 3'b000,
        WBLU_OP_1 = 3'b001,
        WBLU_OP_2 = 3'b010,
        WBLU_OP_3 = 3'b011,
        WBLU_OP_4 = 3'b100
    } wblu_op_t;
    typedef struct packed {
        logic unit_min;
        logic out_inv;
        logic [3:0] in_inv;
        wblu_op_t op;
        logic [5:0] sel_d;
        logic [5:0] sel_c;
        logic [5:0] sel_b;
        logic [5:0] sel_a;
    } wblu_cfg_t;
    typedef struct packed {
        logic [13:0] off_dly;
        logic [13:0] on_dly;
    } wblu_dly_t;
    typedef struct packed {
        logic [2:0] func;
        logic [3:0] src;
    } wblu_iev_t;
endpackage

// ===== wblu_timer.sv
// ON/OFF delay timer for one work bit
`timescale 1ns/1ns
`include "wblu_consts.svh"
module wblu_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick_s,
    input wire logic unit_min,
    input wire logic [13:0] on_dly,
    input wire logic [13:0] off_dly,
    input wire logic din,
    output logic dout
);
    logic [13:0] cnt_q;
    logic [5:0] pre_q;
    logic dout_q;
    logic unit_tick;
    logic [13:0] lim;
    assign lim = din ? on_dly : off_dly;
    assign unit_tick = tick_s && (!unit_min || pre_q == `WBLU_MIN_PRE);
    assign dout = dout_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 14'h0000;
            pre_q <= 6'h00;
            dout_q <= 1'b0;
        end else if (din == dout_q) begin
            cnt_q <= 14'h0000;
            pre_q <= 6'h00;
        end else if (lim == 14'h0000) begin
            dout_q <= din;
        end else if (unit_tick) begin
            pre_q <= 6'h00;
            if (cnt_q + 14'h0001 >= lim) begin
                dout_q <= din;
                cnt_q <= 14'h0000;
            end else begin
                cnt_q <= cnt_q + 14'h0001;
            end
        end else if (tick_s) begin
            pre_q <= pre_q + 6'h01;
        end
    end
endmodule

// ===== wblu_top.sv
// Work bit logic unit with AXI4-Lite configuration slave
`timescale 1ns/1ns
`include "wblu_consts.svh"
module wblu_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [5:0] event_in,
    input wire logic [3:0] alarm_in,
    input wire logic [15:0] status_in,
    output logic [7:0] work_bit,
    output logic [5:0] iev_state,
    output logic run_mode,
    output logic alarm_assigned,
    output logic [1:0] out_drive
);
    localparam int TICKW = 27;
    logic [5:0] ev_s1_q, ev_s2_q;
    logic [TICKW-1:0] tick_cnt_q;
    logic tick_s;
    logic pon_q, pon_done_q;
    logic run_q, ctrl_run_q;
    wblu_pkg::wblu_cfg_t cfg_q [`WBLU_NUM_WB];
    wblu_pkg::wblu_dly_t dly_q [`WBLU_NUM_WB];
    wblu_pkg::wblu_iev_t iev_q [`WBLU_NUM_IEV];
    logic [3:0] outsel_q [2];
    logic [7:0] logic_res, wb_raw;
    logic [5:0] iev_val;
    logic aw_full_q, w_full_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic wr_go;

    // Selector decode for a condition input
    function automatic logic src_val(input logic [5:0] sel, input logic pon,
            input logic [5:0] ev, input logic [3:0] al, input logic run,
            input logic [15:0] st, input logic [7:0] wb);
        logic v;
        v = 1'b0;
        if (sel == `WBLU_SRC_OFF) v = 1'b0;
        else if (sel == `WBLU_SRC_ON) v = 1'b1;
        else if (sel == `WBLU_SRC_PON) v = pon;
        else if (sel >= `WBLU_SRC_EV1 && sel <= `WBLU_SRC_EV6)
            v = ev[3'(sel - `WBLU_SRC_EV1)];
        else if (sel >= `WBLU_SRC_AL1 && sel <= `WBLU_SRC_AL4)
            v = al[2'(sel - `WBLU_SRC_AL1)];
        else if (sel == `WBLU_SRC_RUN) v = run;
        else if (sel >= `WBLU_SRC_WB1 && sel <= `WBLU_SRC_WB8)
            v = wb[3'(sel - `WBLU_SRC_WB1)];
        else if (sel > `WBLU_SRC_AL4 && sel < `WBLU_SRC_WB1)
            v = st[4'(sel - `WBLU_SRC_AL4 - 6'h01)];
        return v;
    endfunction

    // Internal event source decode
    function automatic logic iev_src(input logic [3:0] s, input logic [5:0] ev,
            input logic [7:0] wb);
        logic v;
        v = 1'b0;
        if (s >= `WBLU_IEV_EV1 && s <= `WBLU_IEV_EV6)
            v = ev[3'(s - `WBLU_IEV_EV1)];
        else if (s >= `WBLU_IEV_WB1 && s <= `WBLU_IEV_WB8)
            v = wb[3'(s - `WBLU_IEV_WB1)];
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
            input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_s1_q <= 6'h00;
            ev_s2_q <= 6'h00;
        end else begin
            ev_s1_q <= event_in;
            ev_s2_q <= ev_s1_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= '0;
        end else if (tick_cnt_q == TICKW'(`WBLU_TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end
    assign tick_s = (tick_cnt_q == TICKW'(`WBLU_TICK_CYC - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pon_q <= 1'b0;
            pon_done_q <= 1'b0;
        end else begin
            pon_q <= !pon_done_q;
            pon_done_q <= 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `WBLU_NUM_WB; g++) begin : gen_wb
            logic [3:0] cond;
            for (genvar k = 0; k < 4; k++) begin : gen_in
                logic [5:0] sel;
                assign sel = (k == 0) ? cfg_q[g].sel_a : (k == 1) ? cfg_q[g].sel_b :
                    (k == 2) ? cfg_q[g].sel_c : cfg_q[g].sel_d;
                assign cond[k] = cfg_q[g].in_inv[k] ^ src_val(sel, pon_q, ev_s2_q,
                    alarm_in, run_q, status_in, work_bit);
            end
            always_comb begin
                unique case (cfg_q[g].op)
                    wblu_pkg::WBLU_OP_1: logic_res[g] = (cond[0] & cond[1]) | (cond[2] & cond[3]);
                    wblu_pkg::WBLU_OP_2: logic_res[g] = (cond[0] | cond[2]) & (cond[1] | cond[3]);
                    wblu_pkg::WBLU_OP_3: logic_res[g] = |cond;
                    wblu_pkg::WBLU_OP_4: logic_res[g] = &cond;
                    default: logic_res[g] = 1'b0;
                endcase
            end
            wblu_timer u_timer (
                .aclk(aclk),
                .aresetn(aresetn),
                .tick_s(tick_s),
                .unit_min(cfg_q[g].unit_min),
                .on_dly(dly_q[g].on_dly),
                .off_dly(dly_q[g].off_dly),
                .din(logic_res[g]),
                .dout(wb_raw[g])
            );
            assign work_bit[g] = (cfg_q[g].op != wblu_pkg::WBLU_OP_NONE) &&
                (wb_raw[g] ^ cfg_q[g].out_inv);
        end
        for (g = 0; g < `WBLU_NUM_IEV; g++) begin : gen_iev
            assign iev_val[g] = iev_src(iev_q[g].src, ev_s2_q, work_bit);
        end
    endgenerate
    assign iev_state = iev_val;

    always_comb begin
        run_q = ctrl_run_q;
        for (int i = 0; i < `WBLU_NUM_IEV; i++) begin
            if (iev_q[i].func == `WBLU_FN_RUNSTOP && iev_q[i].src != 4'h0)
                run_q = iev_val[i];
        end
    end
    assign run_mode = run_q;

    always_comb begin
        alarm_assigned = 1'b0;
        for (int i = 0; i < 2; i++) begin
            out_drive[i] = 1'b0;
            if (outsel_q[i] >= `WBLU_OUT_WB1 && outsel_q[i] <= `WBLU_OUT_WB8) begin
                alarm_assigned = 1'b1;
                out_drive[i] = work_bit[3'(outsel_q[i] - `WBLU_OUT_WB1)];
            end
        end
    end

    // AXI write channel capture
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign wr_go = aw_full_q && w_full_q && !bvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr[11:0];
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // Register writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            ctrl_run_q <= 1'b1;
            outsel_q[0] <= `WBLU_OUT_NONE;
            outsel_q[1] <= `WBLU_OUT_NONE;
            for (int i = 0; i < `WBLU_NUM_WB; i++) begin
                cfg_q[i] <= '0;
                dly_q[i] <= '0;
            end
            for (int i = 0; i < `WBLU_NUM_IEV; i++) iev_q[i] <= '0;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= 2'b00;
            if (awaddr_q[11:2] == `WBLU_A_CTRL >> 2) begin
                if (wstrb_q[0]) ctrl_run_q <= wdata_q[0];
            end else if (awaddr_q[11:2] == `WBLU_A_OUTS >> 2) begin
                if (wstrb_q[0]) outsel_q[0] <= wdata_q[3:0];
                if (wstrb_q[1]) outsel_q[1] <= wdata_q[11:8];
            end else if (awaddr_q[11:5] == `WBLU_A_IEV >> 5 && awaddr_q[4:2] >= 3'h2
                    && 4'(awaddr_q[4:2]) < 4'h2 + 4'(`WBLU_NUM_IEV)) begin
                // reject comm write on work bit
                if (wdata_q[6:4] == `WBLU_FN_COMMWR && wdata_q[3:0] >= `WBLU_IEV_WB1)
                    bresp_q <= 2'b10;
                else
                    iev_q[awaddr_q[4:2] - 3'h2] <= 7'(merge({25'h0,
                        iev_q[awaddr_q[4:2] - 3'h2]}, wdata_q, wstrb_q));
            end else if (awaddr_q[11:5] == `WBLU_A_WBCFG >> 5) begin
                cfg_q[awaddr_q[4:2]][31:0] <= merge(cfg_q[awaddr_q[4:2]][31:0], wdata_q, wstrb_q);
            end else if (awaddr_q[11:5] == `WBLU_A_WBDLY >> 5) begin
                if (cfg_q[awaddr_q[4:2]].op == wblu_pkg::WBLU_OP_NONE)
                    bresp_q <= 2'b10;
                else if (wdata_q[13:0] > `WBLU_DLY_MAX || wdata_q[29:16] > `WBLU_DLY_MAX)
                    bresp_q <= 2'b10;
                else begin
                    dly_q[awaddr_q[4:2]] <= {wdata_q[29:16], wdata_q[13:0]};
                    cfg_q[awaddr_q[4:2]].unit_min <= wdata_q[31];
                end
            end else if (awaddr_q[11:2] != `WBLU_A_STAT >> 2) begin
                bresp_q <= 2'b11;
            end
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Register reads
    assign s_axi_arready = !rvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b00;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= 2'b00;
            rdata_q <= 32'h00000000;
            if (s_axi_araddr[11:2] == `WBLU_A_CTRL >> 2)
                rdata_q <= {31'h0, ctrl_run_q};
            else if (s_axi_araddr[11:2] == `WBLU_A_STAT >> 2)
                rdata_q <= {15'h0, alarm_assigned, run_q, 1'b0, iev_val, work_bit};
            else if (s_axi_araddr[11:2] == `WBLU_A_OUTS >> 2)
                rdata_q <= {20'h0, outsel_q[1], 4'h0, outsel_q[0]};
            else if (s_axi_araddr[11:5] == `WBLU_A_IEV >> 5 && s_axi_araddr[4:2] >= 3'h2
                    && 4'(s_axi_araddr[4:2]) < 4'h2 + 4'(`WBLU_NUM_IEV))
                rdata_q <= {25'h0, iev_q[s_axi_araddr[4:2] - 3'h2]};
            else if (s_axi_araddr[11:5] == `WBLU_A_WBCFG >> 5)
                rdata_q <= cfg_q[s_axi_araddr[4:2]][31:0];
            else if (s_axi_araddr[11:5] == `WBLU_A_WBDLY >> 5)
                rdata_q <= {cfg_q[s_axi_araddr[4:2]].unit_min, 1'h0,
                    dly_q[s_axi_araddr[4:2]][27:14], 2'h0,
                    dly_q[s_axi_araddr[4:2]][13:0]};
            else
                rresp_q <= 2'b11;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule

// ===== wblu_chk.sv
// Port protocol checker for the work bit logic unit
`timescale 1ns/1ns
module wblu_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic alarm_assigned,
    input wire logic [1:0] out_drive
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_w_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write taken while response pending");
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_block: assert property (p_r_block) else $error("read taken while data pending");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response late");
    property p_b_cause;
        $rose(s_axi_bvalid) |-> $past(s_axi_wvalid && s_axi_wready, 2)
            || $past(s_axi_awvalid && s_axi_awready, 2);
    endproperty
    a_b_cause: assert property (p_b_cause) else $error("write response without request");
    property p_r_cause;
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
    endproperty
    a_r_cause: assert property (p_r_cause) else $error("read data without request");
    property p_out_idle;
        !alarm_assigned |-> out_drive == 2'b00;
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("output driven unassigned");
endmodule
bind wblu_top wblu_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .alarm_assigned, .out_drive);

// ===== wblu_top_test.sv
// Self-checking testbench for the work bit logic unit
`timescale 1ns/1ns
`include "wblu_consts.svh"
module wblu_top_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF, alarm_in = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [5:0] event_in = 6'h00;
    logic [15:0] status_in = 16'h0000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, out_drive;
    logic [31:0] s_axi_rdata, rd;
    logic [7:0] work_bit;
    logic [5:0] iev_state;
    logic run_mode, alarm_assigned;
    int n_mismatch = 0;
    int n_tests = 0;
    always #4 aclk = ~aclk;
    wblu_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .event_in, .alarm_in, .status_in,
        .work_bit, .iev_state, .run_mode, .alarm_assigned, .out_drive);
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: resp %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk_resp(s_axi_bresp, er);
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk_resp(s_axi_rresp, er);
    endtask
    task automatic settle;
        repeat (6) @(posedge aclk);
    endtask
    function automatic logic [31:0] wa(input int n, input logic [11:0] base);
        return {20'h0, base} + 32'(4 * n);
    endfunction
    function automatic logic [31:0] cfg(input logic [2:0] op, input logic [5:0] a,
        input logic [3:0] inv, input logic oinv);
        return {oinv, inv, op, 18'h0, a};
    endfunction
    function automatic logic comb(input logic [2:0] op, input logic [3:0] v);
        case (op)
            3'h1: return (v[0] & v[1]) | (v[2] & v[3]);
            3'h2: return (v[0] | v[2]) & (v[1] | v[3]);
            3'h3: return |v;
            default: return &v;
        endcase
    endfunction
    task automatic stop_test;
        $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic t_reset;
        chk_val(32'(work_bit), 32'h0);
        chk_val(32'(run_mode), 32'h1);
        axi_rd(wa(0, `WBLU_A_CTRL), rd, 2'b00);
        chk_val(rd & 32'h1, 32'h1);
        $display("t_reset done");
    endtask
    task automatic t_ops;
        logic [3:0] pats [5] = '{4'b0011, 4'b0110, 4'b1001, 4'b0001, 4'b1111};
        logic [23:0] s;
        for (int op = 1; op <= 4; op++) begin
            foreach (pats[i]) begin
                for (int k = 0; k < 4; k++) s[6*k +: 6] = pats[i][k] ? 6'h01 : 6'h00;
                axi_wr(wa(0, `WBLU_A_WBCFG), {5'h0, 3'(op), s}, 2'b00);
                settle();
                chk_val(32'(work_bit[0]), 32'(comb(3'(op), pats[i])));
            end
        end
        axi_wr(wa(7, `WBLU_A_WBCFG), cfg(3'h3, 6'h01, 4'h0, 1'b0), 2'b00);
        settle();
        chk_val(32'(work_bit[7]), 32'h1);
        axi_wr(wa(7, `WBLU_A_WBCFG), cfg(3'h0, 6'h01, 4'h0, 1'b0), 2'b00);
        settle();
        chk_val(32'(work_bit[7]), 32'h0);
        $display("t_ops done");
    endtask
    task automatic t_sel;
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h04, 4'h0, 1'b0), 2'b00);
        event_in <= 6'h02;
        settle();
        chk_val(32'(work_bit[0]), 32'h1);
        event_in <= 6'h01;
        settle();
        chk_val(32'(work_bit[0]), 32'h0);
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h09, 4'h0, 1'b0), 2'b00);
        alarm_in <= 4'h1;
        settle();
        chk_val(32'(work_bit[0]), 32'h1);
        alarm_in <= 4'h2;
        settle();
        chk_val(32'(work_bit[0]), 32'h0);
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h14, 4'h0, 1'b0), 2'b00);
        settle();
        chk_val(32'(work_bit[0]), 32'h1);
        axi_wr(wa(0, `WBLU_A_CTRL), 32'h0, 2'b00);
        settle();
        chk_val(32'(work_bit[0]), 32'h0);
        axi_wr(wa(0, `WBLU_A_CTRL), 32'h1, 2'b00);
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h00, 4'h1, 1'b0), 2'b00);
        settle();
        chk_val(32'(work_bit[0]), 32'h1);
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h01, 4'h0, 1'b1), 2'b00);
        settle();
        chk_val(32'(work_bit[0]), 32'h0);
        $display("t_sel done");
    endtask
    task automatic t_iev;
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h01, 4'h0, 1'b0), 2'b00);
        axi_wr(wa(0, `WBLU_A_IEV), {25'h0, 3'h1, 4'h7}, 2'b00);
        settle();
        chk_val(32'(iev_state[0]), 32'h1);
        chk_val(32'(run_mode), 32'h1);
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h00, 4'h0, 1'b0), 2'b00);
        settle();
        chk_val(32'(run_mode), 32'h0);
        for (int s = 1; s <= 6; s++) begin
            axi_wr(wa(0, `WBLU_A_IEV), {28'h0, 4'(s)}, 2'b00);
            event_in <= 6'(1 << (s - 1));
            settle();
            chk_val(32'(iev_state[0]), 32'h1);
            event_in <= 6'(1 << (s % 6));
            settle();
            chk_val(32'(iev_state[0]), 32'h0);
        end
        axi_wr(wa(0, `WBLU_A_IEV), {25'h0, 3'h2, 4'h7}, 2'b10);
        axi_wr(wa(0, `WBLU_A_IEV), {25'h0, 3'h2, 4'h1}, 2'b00);
        axi_wr(wa(0, `WBLU_A_IEV), 32'h0, 2'b00);
        $display("t_iev done");
    endtask
    task automatic t_err;
        axi_wr(wa(1, `WBLU_A_WBDLY), 32'h0, 2'b10);
        axi_wr(wa(0, `WBLU_A_WBDLY), {2'h2, 14'h270F, 2'h0, 14'h270F}, 2'b00);
        axi_rd(wa(0, `WBLU_A_WBDLY), rd, 2'b00);
        chk_val(rd, {2'h2, 14'h270F, 2'h0, 14'h270F});
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h01, 4'h0, 1'b0), 2'b00);
        settle();
        chk_val(32'(work_bit[0]), 32'h0);
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h00, 4'h0, 1'b0), 2'b00);
        axi_wr(wa(0, `WBLU_A_WBDLY), 32'h0000_2710, 2'b10);
        axi_wr(wa(0, `WBLU_A_WBDLY), 32'h0, 2'b00);
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h01, 4'h0, 1'b0), 2'b00);
        settle();
        axi_wr(wa(0, `WBLU_A_WBDLY), {2'h0, 14'h270F, 16'h0}, 2'b00);
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h00, 4'h0, 1'b0), 2'b00);
        settle();
        chk_val(32'(work_bit[0]), 32'h1);
        axi_wr(wa(0, `WBLU_A_WBDLY), 32'h0, 2'b00);
        settle();
        chk_val(32'(work_bit[0]), 32'h0);
        axi_wr(32'h0000_0800, 32'h0, 2'b11);
        axi_rd(32'h0000_0800, rd, 2'b11);
        $display("t_err done");
    endtask
    task automatic t_out;
        axi_wr(wa(0, `WBLU_A_WBCFG), cfg(3'h3, 6'h01, 4'h0, 1'b0), 2'b00);
        axi_wr(wa(0, `WBLU_A_OUTS), {28'h0, `WBLU_OUT_WB1}, 2'b00);
        settle();
        chk_val(32'(alarm_assigned), 32'h1);
        chk_val(32'(out_drive), 32'h1);
        axi_rd(wa(0, `WBLU_A_STAT), rd, 2'b00);
        chk_val(rd >> 16, 32'h1);
        axi_wr(wa(0, `WBLU_A_OUTS), 32'h0, 2'b00);
        settle();
        chk_val(32'(alarm_assigned), 32'h0);
        $display("t_out done");
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_ops();
        t_sel();
        t_iev();
        t_err();
        t_out();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        stop_test();
    end
endmodule
